// File: bench/mig_checker.sv
// Port assertions for the interrupt gating block
`timescale 1ns/1ps
module mig_checker #(
  parameter PC_W = 13
) (
  input wire clk_sys_i, // Clock
  input wire rst_n_i, // Reset, active low
  input wire hreadyout_o, // Slave ready
  input wire hresp_o, // Response
  input wire sleep_i, // Sleep entry
  input wire irq_ack_i, // Interrupt taken
  input wire retfie_i, // Return
  input wire [PC_W-1:0] ret_pc_i, // PC to push
  input wire [PC_W-1:0] ret_pc_o, // Stack top
  input wire core_irq_o, // Core request
  input wire wake_o, // Wake pulse
  input wire vector_o // Vector pulse
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  bus_ready_a: assert property (hreadyout_o == 1'b1)
    else $error("hreadyout low");
  resp_okay_a: assert property (hresp_o == 1'b0)
    else $error("hresp not okay");
  pc_push_a: assert property (irq_ack_i |=> ret_pc_o == $past(ret_pc_i))
    else $error("return pc not pushed");
  pc_hold_a: assert property (!irq_ack_i && !retfie_i |=> $stable(ret_pc_o))
    else $error("stack top moved");
  entry_masks_a: assert property (irq_ack_i |=> !core_irq_o)
    else $error("request after entry");
  sleep_quiet_a: assert property (sleep_i |=> !core_irq_o)
    else $error("request while asleep");
  wake_pulse_a: assert property (wake_o |=> !wake_o)
    else $error("wake longer than a cycle");
  vector_wake_a: assert property (vector_o |-> wake_o)
    else $error("vector without wake");
endmodule // mig_checker

// File: bench/mig_core_model.sv
// Core sequencer model: takes the request and returns from service
`timescale 1ns/1ps
module mig_core_model (
  input wire clk_sys_i, // Clock
  input wire rst_n_i, // Reset, active low
  input wire core_irq_i, // Gated request
  input wire ack_en_i, // Allow taking
  input wire ret_req_i, // Return request
  output reg irq_ack_o, // Take pulse
  output reg retfie_o // Return pulse
);
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_ack_o <= 1'b0;
      retfie_o <= 1'b0;
    end else begin
      // One pulse only: the request falls once entry masks it
      irq_ack_o <= ack_en_i & core_irq_i & ~irq_ack_o;
      retfie_o <= ret_req_i;
    end
  end
endmodule // mig_core_model

// File: bench/tb.sv
// Self-checking bench for the interrupt gating block
`timescale 1ns/1ps
`include "mig_defines.vh"
module tb;
  reg clk_sys_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [31:0] haddr = 32'h0000_0000;
  reg [31:0] hwdata = 32'h0000_0000;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg pin = 1'b1;
  reg rollover = 1'b0;
  reg sleep = 1'b0;
  reg ack_en = 1'b0;
  reg ret_req = 1'b0;
  reg [3:0] port = 4'h0;
  reg [7:0] pevt = 8'h00;
  reg [12:0] pc = 13'h1A5C;
  reg [31:0] rd;
  wire [31:0] hrdata;
  wire [12:0] ret_pc;
  wire hrdy, hresp, irq_ack, retfie, core_irq, wake, vector, irq;
  int miscompares = 0;
  int n_tests = 0;
  localparam [31:0] A_ICTL = 4 * `MIG_IDX_ICTL;
  localparam [31:0] A_PFLAG = 4 * `MIG_IDX_PFLAG;
  localparam [31:0] A_PEN = 4 * `MIG_IDX_PEN;
  localparam [31:0] A_CFG = 4 * `MIG_IDX_CFG;
  localparam [31:0] A_EVST = 4 * `MIG_IDX_EVSTAT;
  localparam [31:0] A_EVCLR = 4 * `MIG_IDX_EVCLR;
  localparam [31:0] A_EVEN = 4 * `MIG_IDX_EVEN;
  localparam [31:0] A_CORE = 4 * `MIG_IDX_CORE;
  always #25 clk_sys_i = ~clk_sys_i;
  mig_top #(.PC_W(13)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
    .hresp_o(hresp), .ext_irq_pin_i(pin), .port_hi_i(port), .timer_rollover_i(rollover),
    .periph_evt_i(pevt), .sleep_i(sleep), .irq_ack_i(irq_ack), .retfie_i(retfie),
    .ret_pc_i(pc), .core_irq_o(core_irq), .wake_o(wake), .vector_o(vector),
    .ret_pc_o(ret_pc), .irq_o(irq));
  mig_core_model core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .core_irq_i(core_irq),
    .ack_en_i(ack_en), .ret_req_i(ret_req), .irq_ack_o(irq_ack), .retfie_o(retfie));
  ////////////////////////////////////////
  task give_verdict;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Slave answers at once, but the wait stays bounded anyway
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (hrdy !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      give_verdict;
    end
  endtask
  task bus(input w, input [31:0] a, input [31:0] d);
    @(posedge clk_sys_i);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  task rdchk(input string nm, input [31:0] a, input [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask
  // Output picked by selector after the negedge, once it has settled
  task irqchk(input string nm, input exp, input int sel);
    logic got;
    @(negedge clk_sys_i);
    case (sel)
      0: got = core_irq;
      1: got = irq;
      2: got = wake;
      default: got = vector;
    endcase
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask
  ////////////////////////////////////////
  task t_reset;
    rdchk("ictl", A_ICTL, 32'h0000_0000);
    rdchk("pflag", A_PFLAG, 32'h0000_0000);
    rdchk("pen", A_PEN, 32'h0000_0000);
    bus(1'b1, 32'h0000_0100, 32'h0000_00FF);
    rdchk("unmapped", 32'h0000_0100, 32'h0000_0000);
    $display("reset test done");
  endtask
  task t_ext;
    @(posedge clk_sys_i) pin <= 1'b0;
    rdchk("fall flag", A_ICTL, 32'h0000_0002);
    bus(1'b1, A_ICTL, 32'h0000_0082);
    irqchk("ext masked", 1'b0, 0);
    bus(1'b1, A_ICTL, 32'h0000_0092);
    irqchk("ext req", 1'b1, 0);
    bus(1'b1, A_CFG, 32'h0000_0001);
    rdchk("cfg", A_CFG, 32'h0000_0001);
    bus(1'b1, A_ICTL, 32'h0000_0000);
    @(posedge clk_sys_i) pin <= 1'b1;
    rdchk("rise flag", A_ICTL, 32'h0000_0002);
    bus(1'b1, A_ICTL, 32'h0000_0000);
    @(posedge clk_sys_i) pin <= 1'b0;
    rdchk("fall ignored", A_ICTL, 32'h0000_0000);
    $display("external edge test done");
  endtask
  task t_src;
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, A_ICTL, 32'h0000_0080);
      @(posedge clk_sys_i);
      if (k == 1) rollover <= 1'b1;
      else port <= 4'h8;
      @(posedge clk_sys_i) rollover <= 1'b0;
      rdchk("src flag", A_ICTL, k ? 32'h0000_0084 : 32'h0000_0081);
      irqchk("src masked", 1'b0, 0);
      bus(1'b1, A_ICTL, k ? 32'h0000_00A4 : 32'h0000_0089);
      irqchk("src req", 1'b1, 0);
    end
    $display("timer and port test done");
  endtask
  task t_periph;
    int n;
    bus(1'b1, A_ICTL, 32'h0000_0080);
    bus(1'b1, A_PEN, 32'h0000_0020);
    @(posedge clk_sys_i) pevt <= 8'h20;
    @(posedge clk_sys_i) pevt <= 8'h00;
    rdchk("rx flag", A_PFLAG, 32'h0000_0020);
    irqchk("no periph en", 1'b0, 0);
    bus(1'b1, A_ICTL, 32'h0000_00C0);
    irqchk("rx req", 1'b1, 0);
    @(posedge clk_sys_i) ack_en <= 1'b1;
    n = 0;
    while (core_irq !== 1'b0 && n < 10) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk("ack drop", 32'h0, {31'h0, core_irq});
    if (n >= 10) give_verdict;
    chk("ret pc", {19'h0, pc}, {19'h0, ret_pc});
    @(posedge clk_sys_i) ack_en <= 1'b0;
    rdchk("gie off", A_ICTL, 32'h0000_0040);
    rdchk("in service", A_CORE, 32'h0000_0002);
    @(posedge clk_sys_i) ret_req <= 1'b1;
    @(posedge clk_sys_i) ret_req <= 1'b0;
    rdchk("gie back", A_ICTL, 32'h0000_00C0);
    $display("peripheral test done");
  endtask
  // Second pass: no global enable, so wake without vector, status masked
  task t_sleep;
    bus(1'b1, A_PFLAG, 32'h0000_0000);
    for (int g = 0; g < 2; g++) begin
      bus(1'b1, A_ICTL, g ? 32'h0000_0010 : 32'h0000_0090);
      bus(1'b1, A_EVEN, g ? 32'h0000_0000 : 32'h0000_0003);
      @(posedge clk_sys_i) pin <= 1'b0;
      @(posedge clk_sys_i) sleep <= 1'b1;
      @(posedge clk_sys_i) sleep <= 1'b0;
      @(posedge clk_sys_i) pin <= 1'b1;
      // Flag sets one edge after the pin; wake, vector and status the edge after
      repeat (2) @(posedge clk_sys_i);
      irqchk("wake pulse", 1'b1, 2);
      chk("vector pulse", g ? 32'h0000_0000 : 32'h0000_0001, {31'h0, vector});
      rdchk("wake status", A_EVST, g ? 32'h0000_0001 : 32'h0000_0003);
      irqchk("event irq", g ? 1'b0 : 1'b1, 1);
      bus(1'b1, A_EVCLR, 32'h0000_0003);
      rdchk("status clear", A_EVST, 32'h0000_0000);
    end
    $display("sleep test done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_ext;
    t_src;
    t_periph;
    t_sleep;
    give_verdict;
  end
endmodule // tb
bind mig_top mig_checker #(.PC_W(PC_W)) chk_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .sleep_i(sleep_i), .irq_ack_i(irq_ack_i),
  .retfie_i(retfie_i), .ret_pc_i(ret_pc_i), .ret_pc_o(ret_pc_o), .core_irq_o(core_irq_o),
  .wake_o(wake_o), .vector_o(vector_o));

// File: rtl/mig_defines.vh
// Register map, field positions, reset values and sizes for the interrupt gating block
`ifndef MIG_DEFINES_VH
`define MIG_DEFINES_VH

// Printed register indices, byte address is four times the index
`define MIG_IDX_ICTL 8'h0B
`define MIG_IDX_PFLAG 8'h0C
`define MIG_IDX_PEN 8'h8C
// Registers of our own, in index space
`define MIG_IDX_CFG 8'hC0
`define MIG_IDX_EVSTAT 8'hC1
`define MIG_IDX_EVCLR 8'hC2
`define MIG_IDX_EVEN 8'hC3
`define MIG_IDX_CORE 8'hC4

// interrupt_control fields
`define MIG_B_PCF 0
`define MIG_B_EXF 1
`define MIG_B_TOF 2
`define MIG_B_PCE 3
`define MIG_B_EXE 4
`define MIG_B_TOE 5
`define MIG_B_PIE 6
`define MIG_B_GIE 7
// peripheral_flags / peripheral_enables fields
`define MIG_B_RX 5
`define MIG_B_PSP 7
// config register fields
`define MIG_B_EDGE 0
// core status fields
`define MIG_B_SLEEP 0
`define MIG_B_INISR 1

`define MIG_ICTL_RST 8'h00
`define MIG_PFLAG_RST 8'h00
`define MIG_PEN_RST 8'h00
`define MIG_CFG_RST 8'h00

// Event status bits
`define MIG_EV_WAKE 0
`define MIG_EV_VECT 1
`define MIG_EV_W 2

`define MIG_PC_W 13
`define MIG_STACK_DEPTH 8

`endif

// File: rtl/mig_stack.v
// Return address stack, holds only the program counter
`timescale 1ns/1ps
`include "mig_defines.vh"
module mig_stack #(
  parameter DW = `MIG_PC_W,
  parameter DEPTH = `MIG_STACK_DEPTH,
  parameter AW = 3
) (
  input wire clk_sys_i, // System clock
  input wire rst_n_i, // Async reset, active low
  input wire push_i, // Push strobe
  input wire pop_i, // Pop strobe
  input wire [DW-1:0] din_i, // Value to push
  output reg [DW-1:0] dout_o // Top of stack, registered
);
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] ptr_q;
  reg [AW:0] fill_q;
  wire [AW-1:0] top_w;

  // Circular, like the core stack: overflow wraps silently
  assign top_w = ptr_q - {{(AW-1){1'b0}}, 1'b1};

  always @(posedge clk_sys_i) begin
    if (push_i) begin
      mem[ptr_q] <= din_i;
    end
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_q <= {AW{1'b0}};
      fill_q <= {(AW+1){1'b0}};
      dout_o <= {DW{1'b0}};
    end else if (push_i) begin
      ptr_q <= ptr_q + {{(AW-1){1'b0}}, 1'b1};
      dout_o <= din_i;
      if (fill_q < DEPTH) begin
        fill_q <= fill_q + {{AW{1'b0}}, 1'b1};
      end
    end else if (pop_i) begin
      ptr_q <= top_w;
      if (fill_q > {{AW{1'b0}}, 1'b1}) begin
        dout_o <= mem[top_w - {{(AW-1){1'b0}}, 1'b1}];
      end else begin
        // Empty after this pop: never show a slot nobody wrote
        dout_o <= {DW{1'b0}};
      end
      if (fill_q != {(AW+1){1'b0}}) begin
        fill_q <= fill_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // mig_stack

// File: rtl/mig_top.v
// Interrupt flag, enable and gating logic with AHB-Lite register access
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "mig_defines.vh"
// What this block does
// - External pin edge triggered; polarity bit set rising, clear falling.
// - Qualifying external edge sets ext_edge_flag, control bit 1.
// - ext_edge_enable bit 4 clear suppresses the external request.
// - External edge wakes sleep only if its enable was set before sleep.
// - After wake, vector only when global enable set, else continue.
// - Timer rollover from FFh to zero sets timer_overflow_flag, bit 2.
// - Timer overflow request gated by timer_overflow_enable, bit 5.
// - Any change on upper four port pins sets port_change_flag, bit 0.
// - Port change request gated by port_change_enable, bit 3.
// - Interrupt entry pushes only return PC, nothing else saved.
// - Receive complete sets rx_complete_flag; requests when rx_irq_enable set.
// - Peripheral requests need both global and peripheral enables.
// - Peripheral flags bits 7..0; enable register uses same positions.
module mig_top #(
  parameter PC_W = `MIG_PC_W
) (
  input wire clk_sys_i, // System clock, 20 MHz
  input wire rst_n_i, // Async reset, active low
  input wire hsel_i, // AHB select
  input wire [31:0] haddr_i, // AHB address
  input wire [1:0] htrans_i, // AHB transfer type
  input wire hwrite_i, // AHB write
  input wire [2:0] hsize_i, // AHB size
  input wire [31:0] hwdata_i, // AHB write data
  input wire hready_i, // AHB bus ready
  output reg [31:0] hrdata_o, // AHB read data
  output wire hreadyout_o, // AHB slave ready
  output wire hresp_o, // AHB response, always OKAY
  input wire ext_irq_pin_i, // External interrupt pin
  input wire [3:0] port_hi_i, // Upper four port pins
  input wire timer_rollover_i, // Timer wrapped FFh to 00h, pulse
  input wire [7:0] periph_evt_i, // Peripheral flag set pulses
  input wire sleep_i, // Core enters sleep, pulse
  input wire irq_ack_i, // Core takes the interrupt, pulse
  input wire retfie_i, // Return-from-interrupt, pulse
  input wire [PC_W-1:0] ret_pc_i, // Return PC to save
  output wire core_irq_o, // Gated interrupt request to core
  output reg wake_o, // Wake pulse, registered
  output reg vector_o, // Branch to vector after wake, registered
  output wire [PC_W-1:0] ret_pc_o, // Saved return PC
  output wire irq_o // Block event interrupt
);
  reg [7:0] ictl_q;
  reg [7:0] pflag_q;
  reg [7:0] pen_q;
  reg [7:0] cfg_q;
  reg [`MIG_EV_W-1:0] evst_q;
  reg [`MIG_EV_W-1:0] even_q;
  reg ext_q;
  reg [3:0] port_q;
  reg sleep_q;
  reg insr_q;
  reg ext_en_sleep_q;
  reg dp_wr_q;
  reg dp_rd_q;
  reg [7:0] dp_idx_q;

  wire edge_pol_w;
  wire ext_edge_w;
  wire port_chg_w;
  wire core_req_w;
  wire periph_req_w;
  wire wake_w;
  wire wr_ictl_w;
  wire wr_pflag_w;
  wire [7:0] wdat_w;
  wire [`MIG_EV_W-1:0] ev_set_w;
  wire [`MIG_EV_W-1:0] ev_clr_w;
  wire addr_ph_w;

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, OKAY always

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign addr_ph_w = hsel_i & htrans_i[1] & hready_i;
  assign wdat_w = hwdata_i[7:0];

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_wr_q <= 1'b0;
      dp_rd_q <= 1'b0;
      dp_idx_q <= 8'h00;
    end else begin
      dp_wr_q <= addr_ph_w & hwrite_i;
      dp_rd_q <= addr_ph_w & ~hwrite_i;
      if (addr_ph_w) begin
        dp_idx_q <= haddr_i[9:2];
      end
    end
  end

  assign wr_ictl_w = dp_wr_q & (dp_idx_q == `MIG_IDX_ICTL);
  assign wr_pflag_w = dp_wr_q & (dp_idx_q == `MIG_IDX_PFLAG);

  // Read data registered at the address phase so it stands in the data phase
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (addr_ph_w & ~hwrite_i) begin
      case (haddr_i[9:2])
        `MIG_IDX_ICTL: hrdata_o <= {24'h00_0000, ictl_q};
        `MIG_IDX_PFLAG: hrdata_o <= {24'h00_0000, pflag_q};
        `MIG_IDX_PEN: hrdata_o <= {24'h00_0000, pen_q};
        `MIG_IDX_CFG: hrdata_o <= {24'h00_0000, cfg_q};
        `MIG_IDX_EVSTAT: hrdata_o <= {30'h0000_0000, evst_q};
        `MIG_IDX_EVEN: hrdata_o <= {30'h0000_0000, even_q};
        `MIG_IDX_CORE: hrdata_o <= {30'h0000_0000, insr_q, sleep_q};
        default: hrdata_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Source edge detection; pins taken as synchronous

  assign edge_pol_w = cfg_q[`MIG_B_EDGE];
  assign ext_edge_w = edge_pol_w ? (ext_irq_pin_i & ~ext_q)
                                 : (~ext_irq_pin_i & ext_q);
  assign port_chg_w = |(port_hi_i ^ port_q);

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_q <= 1'b0;
      port_q <= 4'h0;
    end else begin
      ext_q <= ext_irq_pin_i;
      port_q <= port_hi_i;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control register and flags; hardware set wins over software clear

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ictl_q <= `MIG_ICTL_RST;
    end else begin
      if (wr_ictl_w) begin
        ictl_q[7:3] <= wdat_w[7:3];
        ictl_q[2:0] <= wdat_w[2:0];
      end
      // Flag stays until software writes zero
      if (ext_edge_w) begin
        ictl_q[`MIG_B_EXF] <= 1'b1;
      end
      if (timer_rollover_i) begin
        ictl_q[`MIG_B_TOF] <= 1'b1;
      end
      if (port_chg_w) begin
        ictl_q[`MIG_B_PCF] <= 1'b1;
      end
      if (irq_ack_i) begin
        ictl_q[`MIG_B_GIE] <= 1'b0;
      end else if (retfie_i) begin
        ictl_q[`MIG_B_GIE] <= 1'b1;
      end
    end
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pflag_q <= `MIG_PFLAG_RST;
      pen_q <= `MIG_PEN_RST;
      cfg_q <= `MIG_CFG_RST;
      even_q <= {`MIG_EV_W{1'b0}};
    end else begin
      // All eight positions are kept; small variants leave bit 7 clear by software
      pflag_q <= (wr_pflag_w ? wdat_w : pflag_q) | periph_evt_i;
      if (dp_wr_q & (dp_idx_q == `MIG_IDX_PEN)) begin
        pen_q <= wdat_w;
      end
      if (dp_wr_q & (dp_idx_q == `MIG_IDX_CFG)) begin
        cfg_q <= {7'h00, wdat_w[`MIG_B_EDGE]};
      end
      if (dp_wr_q & (dp_idx_q == `MIG_IDX_EVEN)) begin
        even_q <= wdat_w[`MIG_EV_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Request gating

  assign periph_req_w = ictl_q[`MIG_B_PIE] & (|(pflag_q & pen_q));
  assign core_req_w = (ictl_q[`MIG_B_EXF] & ictl_q[`MIG_B_EXE])
                    | (ictl_q[`MIG_B_TOF] & ictl_q[`MIG_B_TOE])
                    | (ictl_q[`MIG_B_PCF] & ictl_q[`MIG_B_PCE])
                    | periph_req_w;
  assign core_irq_o = ictl_q[`MIG_B_GIE] & core_req_w & ~sleep_q;

  ////////////////////////////////////////////////////////////////////
  // Sleep and wake

  // Enable is captured at sleep entry, so a late enable cannot wake
  assign wake_w = sleep_q & ext_en_sleep_q & ictl_q[`MIG_B_EXF];

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep_q <= 1'b0;
      ext_en_sleep_q <= 1'b0;
      wake_o <= 1'b0;
      vector_o <= 1'b0;
      insr_q <= 1'b0;
    end else begin
      wake_o <= wake_w;
      vector_o <= wake_w & ictl_q[`MIG_B_GIE];
      if (sleep_i & ~sleep_q) begin
        sleep_q <= 1'b1;
        ext_en_sleep_q <= ictl_q[`MIG_B_EXE];
      end else if (wake_w) begin
        sleep_q <= 1'b0;
      end
      if (irq_ack_i) begin
        insr_q <= 1'b1;
      end else if (retfie_i) begin
        insr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Return address save: only the PC goes on the stack

  mig_stack #(
    .DW(PC_W),
    .DEPTH(`MIG_STACK_DEPTH),
    .AW(3)
  ) u_stack (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .push_i(irq_ack_i),
    .pop_i(retfie_i),
    .din_i(ret_pc_i),
    .dout_o(ret_pc_o)
  );

  ////////////////////////////////////////////////////////////////////
  // Block event interrupt: sticky, write-one-to-clear, set wins

  assign ev_set_w = {wake_w & ictl_q[`MIG_B_GIE], wake_w};
  assign ev_clr_w = (dp_wr_q & (dp_idx_q == `MIG_IDX_EVCLR)) ?
                    wdat_w[`MIG_EV_W-1:0] : {`MIG_EV_W{1'b0}};

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evst_q <= {`MIG_EV_W{1'b0}};
    end else begin
      evst_q <= (evst_q & ~ev_clr_w) | ev_set_w;
    end
  end

  assign irq_o = |(evst_q & even_q);
endmodule // mig_top
